//--- src/monitor_cfg.svh
`ifndef MONITOR_CFG_SVH
`define MONITOR_CFG_SVH
// ==========================================================
// Frame layout (bytes counted from the V5 byte, index 0)
`define J2_INDEX        7'h1A
// ==========================================================
// Persistence counts (frames) and signal label values
`define PERSIST_LAST    3'h4
`define TRACE_LAST      2'h2
`define LABEL_AIS       3'h7
`define LABEL_UNEQ      3'h0
// ==========================================================
// Register word indices
`define REG_CTRL        4'h0
`define REG_DEG_THR     4'h1
`define REG_DEG_WIN     4'h2
`define REG_EXP_TRACE   4'h3
`define REG_ACC_TRACE   4'h4
`define REG_DEFECTS     4'h5
`define REG_REPORTS     4'h6
`define REG_PERF        4'h7
`define REG_NEAR_EBC    4'h8
`define REG_FAR_EBC     4'h9
`define REG_IRQ_STATUS  4'hA
`define REG_IRQ_MASK    4'hB
`define REG_SIG_LABEL   4'hC
// ==========================================================
// Control fields and reset values
`define CTRL_MON        0
`define CTRL_TIM_DIS    1
`define CTRL_SF_REP     2
`define CTRL_RDI_REP    3
`define CTRL_RESET      4'hD
`define DEG_THR_RESET   16'h0001
`define DEG_WIN_RESET   4'h2
`endif

//--- src/monitor_pkg.sv
package monitor_pkg;
   // Path defect set
   typedef struct packed {
      logic rdi;
      logic deg;
      logic tim;
      logic uneq;
      logic ais;
   } defect_t;
   // Management reports
   typedef struct packed {
      logic sf;
      logic rdi;
      logic deg;
      logic tim;
      logic uneq;
   } report_t;
   // Bus request phase
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_t;
endpackage

//--- src/vc11_monitor.sv
`include "monitor_cfg.svh"
module vc11_monitor
   import monitor_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  ci_byte,
   input  wire logic        ci_byte_valid,
   input  wire logic        ci_frame_start,
   input  wire logic        incoming_server_fail,
   input  wire logic        equipment_defect,
   input  wire logic        one_second_tick,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq,
   output logic             trail_signal_fail,
   output logic             trail_signal_degrade,
   output report_t          reports,
   output logic             near_defect_second,
   output logic             far_defect_second
);

   // ==========================================================
   // Frame alignment
   logic [6:0]  byte_idx_reg;     // Byte position after V5
   logic        frame_seen_reg;   // A frame start has been seen
   logic        v5_strobe;        // This byte is V5
   logic        j2_strobe;        // This byte is J2
   logic [2:0]  label;            // V5 bits 5-7
   logic [1:0]  byte_bip;         // Pair parity of this byte

   assign v5_strobe = ci_byte_valid & ci_frame_start;
   // Only V5 and J2 are picked; N2 and K4 pass unread
   assign j2_strobe = ci_byte_valid & ~ci_frame_start & frame_seen_reg
                      & (byte_idx_reg == `J2_INDEX);
   assign label     = ci_byte[3:1];
   assign byte_bip  = {ci_byte[7] ^ ci_byte[5] ^ ci_byte[3] ^ ci_byte[1],
                       ci_byte[6] ^ ci_byte[4] ^ ci_byte[2] ^ ci_byte[0]};

   // Byte counter, restarted by each frame start
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         byte_idx_reg   <= 7'h00;
         frame_seen_reg <= 1'b0;
      end else if (ci_byte_valid) begin
         if (ci_frame_start) begin
            byte_idx_reg   <= 7'h01;
            frame_seen_reg <= 1'b1;
         end else begin
            byte_idx_reg <= byte_idx_reg + 7'h01;
         end
      end
   end

   // ==========================================================
   // Error detection code and far-end errors
   logic [1:0]  bip_acc_reg;      // Parity of frame so far
   logic        bip_ok_reg;       // A whole frame was covered
   logic        near_err_reg;     // Near-end errored block pulse
   logic        far_err_reg;      // Far-end errored block pulse

   // Parity restarts with V5 itself so V5 counts in next check
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bip_acc_reg  <= 2'h0;
         bip_ok_reg   <= 1'b0;
         near_err_reg <= 1'b0;
         far_err_reg  <= 1'b0;
      end else begin
         near_err_reg <= v5_strobe & bip_ok_reg
                         & (ci_byte[7:6] != bip_acc_reg);
         far_err_reg  <= v5_strobe & ci_byte[5];
         if (v5_strobe) begin
            bip_acc_reg <= byte_bip;
            bip_ok_reg  <= 1'b1;
         end else if (ci_byte_valid) begin
            bip_acc_reg <= bip_acc_reg ^ byte_bip;
         end
      end
   end

   // ==========================================================
   // Control registers
   logic [3:0]  ctrl_reg;         // Mode and report enables
   logic [15:0] deg_thr_reg;      // degrade_threshold
   logic [3:0]  deg_win_reg;      // degrade_window_count
   logic [7:0]  exp_trace_reg;    // expected_trace
   logic [5:0]  irq_mask_reg;     // Interrupt enables
   logic        monitoring_on;
   logic        server_gate;      // Server fail or AIS
   defect_t     def_reg;          // Current defects

   assign monitoring_on = ctrl_reg[`CTRL_MON];
   assign server_gate   = incoming_server_fail | def_reg.ais;

   // ==========================================================
   // Signal label, AIS and remote defect filters
   logic [2:0]  sl_last_reg;      // Last label seen
   logic [2:0]  sl_cnt_reg;       // Repeats of last label
   logic [2:0]  sl_acc_reg;       // Accepted label
   logic [2:0]  ais_run_reg;      // Frames against AIS state
   logic        rdi_raw_reg;      // Accepted V5 bit 8
   logic [2:0]  rdi_run_reg;      // Frames against bit 8 state
   logic        sl_ok_reg;        // A label has been accepted

   // Each state flips after five frames of the opposite kind
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sl_last_reg <= 3'h0;
         sl_cnt_reg  <= 3'h0;
         sl_acc_reg  <= 3'h0;
         sl_ok_reg   <= 1'b0;
         rdi_raw_reg <= 1'b0;
         rdi_run_reg <= 3'h0;
      end else if (v5_strobe) begin
         // Label acceptance
         if (label != sl_last_reg) begin
            sl_last_reg <= label;
            sl_cnt_reg  <= 3'h1; // This frame is the first of the run
         end else if (sl_cnt_reg == `PERSIST_LAST) begin
            sl_acc_reg <= label;
            sl_ok_reg  <= 1'b1;
         end else begin
            sl_cnt_reg <= sl_cnt_reg + 3'h1;
         end
         // Remote defect indication bit
         if (ci_byte[0] == rdi_raw_reg) begin
            rdi_run_reg <= 3'h0;
         end else if (rdi_run_reg == `PERSIST_LAST) begin
            rdi_raw_reg <= ci_byte[0];
            rdi_run_reg <= 3'h0;
         end else begin
            rdi_run_reg <= rdi_run_reg + 3'h1;
         end
      end
   end

   // ==========================================================
   // Trail trace acceptance
   logic [7:0]  j2_last_reg;      // Last J2 value
   logic [1:0]  j2_cnt_reg;       // Repeats of last J2
   logic [7:0]  acc_trace_reg;    // accepted_trace
   logic        trace_ok_reg;     // A trace has been accepted

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         j2_last_reg   <= 8'h00;
         j2_cnt_reg    <= 2'h0;
         acc_trace_reg <= 8'h00;
         trace_ok_reg  <= 1'b0;
      end else if (j2_strobe) begin
         if (ci_byte != j2_last_reg) begin
            j2_last_reg <= ci_byte;
            j2_cnt_reg  <= 2'h1; // This frame is the first of the run
         end else if (j2_cnt_reg == `TRACE_LAST) begin
            acc_trace_reg <= ci_byte;
            trace_ok_reg  <= 1'b1;
         end else begin
            j2_cnt_reg <= j2_cnt_reg + 2'h1;
         end
      end
   end

   // ==========================================================
   // Gated defects and degrade evaluation
   logic [15:0] near_acc_reg;     // Near errors this second
   logic [15:0] far_acc_reg;      // Far errors this second
   logic        gate_sec_reg;     // Gate seen this second
   logic [3:0]  deg_run_reg;      // Seconds against degrade
   logic        bad_sec;          // Second over threshold

   assign bad_sec = (near_acc_reg >= deg_thr_reg) & ~gate_sec_reg;

   // Defects other than AIS clear while the server gate stands
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         def_reg.ais  <= 1'b0;
         ais_run_reg  <= 3'h0;
         def_reg.uneq <= 1'b0;
         def_reg.tim  <= 1'b0;
         def_reg.rdi  <= 1'b0;
         def_reg.deg  <= 1'b0;
         deg_run_reg  <= 4'h0;
      end else begin
         // Declare or clear AIS on each V5 byte
         if (v5_strobe) begin
            if ((label == `LABEL_AIS) == def_reg.ais) begin
               ais_run_reg <= 3'h0;
            end else if (ais_run_reg == `PERSIST_LAST) begin
               def_reg.ais <= ~def_reg.ais;
               ais_run_reg <= 3'h0;
            end else begin
               ais_run_reg <= ais_run_reg + 3'h1;
            end
         end
         // No unequipped defect before any label is accepted
         def_reg.uneq <= (sl_acc_reg == `LABEL_UNEQ) & sl_ok_reg
                         & ~server_gate;
         def_reg.tim  <= trace_ok_reg & (acc_trace_reg != exp_trace_reg)
                         & ~ctrl_reg[`CTRL_TIM_DIS] & ~server_gate;
         def_reg.rdi  <= rdi_raw_reg & ~server_gate;
         if (server_gate) begin
            def_reg.deg <= 1'b0;
            deg_run_reg <= 4'h0;
         end else if (one_second_tick) begin
            if (bad_sec == def_reg.deg) begin
               deg_run_reg <= 4'h0;
            end else if (deg_run_reg + 4'h1 >= deg_win_reg) begin
               def_reg.deg <= bad_sec;
               deg_run_reg <= 4'h0;
            end else begin
               deg_run_reg <= deg_run_reg + 4'h1;
            end
         end
      end
   end

   // ==========================================================
   // Consequent actions and correlations
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         trail_signal_fail    <= 1'b0;
         trail_signal_degrade <= 1'b0;
         reports              <= '0;
      end else begin
         trail_signal_fail    <= server_gate | def_reg.uneq | def_reg.tim;
         trail_signal_degrade <= def_reg.deg;
         reports.uneq <= def_reg.uneq & monitoring_on;
         reports.tim  <= def_reg.tim & ~def_reg.uneq & monitoring_on;
         reports.deg  <= def_reg.deg & ~def_reg.tim & monitoring_on;
         reports.rdi  <= def_reg.rdi & ~def_reg.uneq & ~def_reg.tim
                         & monitoring_on & ctrl_reg[`CTRL_RDI_REP];
         reports.sf   <= server_gate & monitoring_on
                         & ctrl_reg[`CTRL_SF_REP];
      end
   end

   // ==========================================================
   // Performance accumulation per second
   logic        near_ds_acc_reg;  // Near defect seen
   logic        far_ds_acc_reg;   // Far defect seen
   logic [15:0] near_ebc_reg;     // Latched near count
   logic [15:0] far_ebc_reg;      // Latched far count

   // Tick latches the second and restarts with this cycle's events
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         near_acc_reg       <= 16'h0000;
         far_acc_reg        <= 16'h0000;
         near_ds_acc_reg    <= 1'b0;
         far_ds_acc_reg     <= 1'b0;
         gate_sec_reg       <= 1'b0;
         near_ebc_reg       <= 16'h0000;
         far_ebc_reg        <= 16'h0000;
         near_defect_second <= 1'b0;
         far_defect_second  <= 1'b0;
      end else if (one_second_tick) begin
         near_ebc_reg       <= near_acc_reg;
         far_ebc_reg        <= far_acc_reg;
         near_defect_second <= near_ds_acc_reg;
         far_defect_second  <= far_ds_acc_reg;
         near_acc_reg       <= {15'h0000, near_err_reg};
         far_acc_reg        <= {15'h0000, far_err_reg};
         near_ds_acc_reg    <= trail_signal_fail | equipment_defect;
         far_ds_acc_reg     <= def_reg.rdi;
         gate_sec_reg       <= server_gate;
      end else begin
         near_acc_reg    <= near_acc_reg + {15'h0000, near_err_reg};
         far_acc_reg     <= far_acc_reg + {15'h0000, far_err_reg};
         near_ds_acc_reg <= near_ds_acc_reg | trail_signal_fail
                            | equipment_defect;
         far_ds_acc_reg  <= far_ds_acc_reg | def_reg.rdi;
         gate_sec_reg    <= gate_sec_reg | server_gate;
      end
   end

   // ==========================================================
   // Interrupt events
   defect_t     def_prev_reg;     // Defects one cycle back
   logic [5:0]  irq_event;        // Rising defects and tick
   logic [5:0]  irq_stat_reg;     // Sticky status
   bus_state_t  bus_state_reg;    // Bus phase
   logic        access;           // Request completes now

   assign irq_event = {one_second_tick, def_reg & ~def_prev_reg};
   assign access    = (avs_read | avs_write) & (bus_state_reg == BUS_ACK);

   // Set wins over a clearing read in the same cycle
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         def_prev_reg <= '0;
         irq_stat_reg <= 6'h00;
         irq          <= 1'b0;
      end else begin
         def_prev_reg <= def_reg;
         if (access & avs_read & (avs_address == `REG_IRQ_STATUS)) begin
            irq_stat_reg <= irq_event;
         end else begin
            irq_stat_reg <= irq_stat_reg | irq_event;
         end
         irq <= |((irq_stat_reg | irq_event) & irq_mask_reg);
      end
   end

   // ==========================================================
   // Avalon slave: one wait cycle per request
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_state_reg   <= BUS_IDLE;
         avs_waitrequest <= 1'b1;
      end else begin
         case (bus_state_reg)
            BUS_IDLE: begin
               if (avs_read | avs_write) begin
                  bus_state_reg   <= BUS_ACK;
                  avs_waitrequest <= 1'b0;
               end
            end
            BUS_ACK: begin
               bus_state_reg   <= BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_state_reg   <= BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Register writes at the acknowledged edge
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg      <= `CTRL_RESET;
         deg_thr_reg   <= `DEG_THR_RESET;
         deg_win_reg   <= `DEG_WIN_RESET;
         exp_trace_reg <= 8'h00;
         irq_mask_reg  <= 6'h00;
      end else if (access & avs_write) begin
         case (avs_address)
            `REG_CTRL:      ctrl_reg      <= avs_writedata[3:0];
            `REG_DEG_THR:   deg_thr_reg   <= avs_writedata[15:0];
            `REG_DEG_WIN:   deg_win_reg   <= avs_writedata[3:0];
            `REG_EXP_TRACE: exp_trace_reg <= avs_writedata[7:0];
            `REG_IRQ_MASK:  irq_mask_reg  <= avs_writedata[5:0];
            default: begin
            end
         endcase
      end
   end

   // Read data prepared while waitrequest is high
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & (bus_state_reg == BUS_IDLE)) begin
         case (avs_address)
            `REG_CTRL:       avs_readdata <= {28'h000_0000, ctrl_reg};
            `REG_DEG_THR:    avs_readdata <= {16'h0000, deg_thr_reg};
            `REG_DEG_WIN:    avs_readdata <= {28'h000_0000, deg_win_reg};
            `REG_EXP_TRACE:  avs_readdata <= {24'h00_0000, exp_trace_reg};
            `REG_ACC_TRACE:  avs_readdata <= {24'h00_0000, acc_trace_reg};
            `REG_DEFECTS:    avs_readdata <= {25'h000_0000, trail_signal_degrade,
                                              trail_signal_fail, def_reg};
            `REG_REPORTS:    avs_readdata <= {27'h000_0000, reports};
            `REG_PERF:       avs_readdata <= {30'h0000_0000, far_defect_second,
                                              near_defect_second};
            `REG_NEAR_EBC:   avs_readdata <= {16'h0000, near_ebc_reg};
            `REG_FAR_EBC:    avs_readdata <= {16'h0000, far_ebc_reg};
            `REG_IRQ_STATUS: avs_readdata <= {26'h000_0000, irq_stat_reg | irq_event};
            `REG_IRQ_MASK:   avs_readdata <= {26'h000_0000, irq_mask_reg};
            `REG_SIG_LABEL:  avs_readdata <= {29'h0000_0000, sl_acc_reg};
            default:         avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Checks
   ais_declare_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      v5_strobe && label == `LABEL_AIS && ais_run_reg == `PERSIST_LAST
      && !def_reg.ais |=> def_reg.ais) else $error("AIS not declared");
   ais_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      v5_strobe && label != `LABEL_AIS && ais_run_reg == `PERSIST_LAST
      && def_reg.ais |=> !def_reg.ais) else $error("AIS not cleared");
   bip_error_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      v5_strobe && bip_ok_reg && ci_byte[7:6] != bip_acc_reg
      |=> near_err_reg ##1 !near_err_reg) else $error("BIP error lost");
   fail_action_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(def_reg.tim) |=> trail_signal_fail) else $error("TSF missing");
   tim_report_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      reports.tim |-> $past(def_reg.tim) && !$past(def_reg.uneq)
      && $past(monitoring_on)) else $error("TIM report wrong");
   deg_report_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      reports.deg |-> $past(!def_reg.tim && def_reg.deg))
      else $error("DEG report wrong");
   rdi_report_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      reports.rdi |-> $past(ctrl_reg[`CTRL_RDI_REP] && def_reg.rdi))
      else $error("RDI report wrong");
   sf_report_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      incoming_server_fail && monitoring_on && ctrl_reg[`CTRL_SF_REP]
      |=> reports.sf) else $error("SF report missing");
   tick_latch_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      one_second_tick |=> near_ebc_reg == $past(near_acc_reg))
      else $error("Count not latched");
   gate_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      incoming_server_fail [*2] |-> !def_reg.uneq && !def_reg.rdi)
      else $error("Gate ignored");

endmodule // vc11_monitor

//--- verification/vc11_path_nonintrusive_monitor_tb.sv
`include "monitor_cfg.svh"
module vc11_path_nonintrusive_monitor_tb
   import monitor_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ======
   // Signals
   logic        sys_clk = 0;
   logic        sys_rst = 1;
   logic [7:0]  ci_byte;
   logic        ci_byte_valid;
   logic        ci_frame_start;
   logic        server_fail = 0;  // Server fail stimulus
   logic        eq_fault = 0;     // Equipment defect stimulus
   logic        tick = 0;         // One-second tick
   logic [3:0]  avs_address = 0;
   logic        avs_read = 0;
   logic        avs_write = 0;
   logic [31:0] avs_writedata = 0;
   logic [31:0] avs_readdata;
   logic [31:0] rd;               // Last word read
   logic        avs_waitrequest;
   logic        irq;
   logic        tsf;
   logic        tsd;
   logic        near_ds;
   logic        far_ds;
   report_t     reports;
   int          fail_count = 0;
   int          num_checks = 0;
   always #5 sys_clk = ~sys_clk;
   vc11_path_source src (.sys_clk(sys_clk), .ci_byte(ci_byte),
      .ci_byte_valid(ci_byte_valid), .ci_frame_start(ci_frame_start));
   vc11_monitor DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .ci_byte(ci_byte),
      .ci_byte_valid(ci_byte_valid), .ci_frame_start(ci_frame_start),
      .incoming_server_fail(server_fail), .equipment_defect(eq_fault),
      .one_second_tick(tick), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq(irq), .trail_signal_fail(tsf), .trail_signal_degrade(tsd),
      .reports(reports), .near_defect_second(near_ds),
      .far_defect_second(far_ds));
   // ======
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // One bus access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      @(posedge sys_clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= wd;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (n == 50) begin
         fail_count++;
         end_of_test();
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] want);
      bus(1'b0, a, 32'h0000_0000);
      check(rd, want);
   endtask
   task automatic frames(input int n, input logic [2:0] l, input logic rei,
                         input logic rdi, input logic bad);
      repeat (n) src.send_frame(l, rei, rdi, bad);
   endtask
   task automatic pulse();
      @(posedge sys_clk);
      tick <= 1'b1;
      @(posedge sys_clk);
      tick <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Hang guard
   initial begin
      #500_000;
      fail_count++;
      end_of_test();
   end
   // ======
   // Main sequence
   initial begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rchk(`REG_CTRL, 32'h0000_000D);
      rchk(`REG_DEG_THR, 32'h0000_0001);
      bus(1'b1, 4'hD, 32'hFFFF_FFFF);
      rchk(4'hD, 32'h0000_0000);
      bus(1'b1, `REG_EXP_TRACE, 32'h0000_00A5);
      bus(1'b1, `REG_IRQ_MASK, 32'h0000_0001);
      // All-ones label: four frames are not enough, the fifth declares
      frames(4, 3'b111, 0, 0, 0);
      check(32'(tsf), 32'h0000_0000);
      frames(1, 3'b111, 0, 0, 0);
      check(32'(tsf), 32'h0000_0001);
      check(32'(reports), 32'h0000_0010);
      check(32'(irq), 32'h0000_0001);
      rchk(`REG_IRQ_STATUS, 32'h0000_0001);
      rchk(`REG_IRQ_STATUS, 32'h0000_0000);
      repeat (2) @(posedge sys_clk);
      check(32'(irq), 32'h0000_0000);
      frames(4, 3'b010, 0, 0, 0);
      check(32'(tsf), 32'h0000_0001);
      frames(1, 3'b010, 0, 0, 0);
      check(32'(tsf), 32'h0000_0000);
      rchk(`REG_ACC_TRACE, 32'h0000_00A5);
      // Server fail, reported then suppressed
      server_fail <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check(32'(tsf), 32'h0000_0001);
      check(32'(reports), 32'h0000_0010);
      bus(1'b1, `REG_CTRL, 32'h0000_0009);
      repeat (2) @(posedge sys_clk);
      check(32'(reports), 32'h0000_0000);
      server_fail <= 1'b0;
      bus(1'b1, `REG_CTRL, 32'h0000_000D);
      // Trace mismatch, then its detection disabled
      bus(1'b1, `REG_EXP_TRACE, 32'h0000_003C);
      frames(1, 3'b010, 0, 0, 0);
      check(32'(tsf), 32'h0000_0001);
      check(32'(reports), 32'h0000_0002);
      bus(1'b1, `REG_CTRL, 32'h0000_000F);
      frames(1, 3'b010, 0, 0, 0);
      check(32'(tsf), 32'h0000_0000);
      bus(1'b1, `REG_EXP_TRACE, 32'h0000_00A5);
      bus(1'b1, `REG_CTRL, 32'h0000_000D);
      // One parity error and two far-end errors in one second
      pulse();
      frames(1, 3'b010, 0, 0, 1);
      frames(2, 3'b010, 1, 0, 0);
      pulse();
      rchk(`REG_NEAR_EBC, 32'h0000_0001);
      rchk(`REG_FAR_EBC, 32'h0000_0002);
      check(32'(far_ds), 32'h0000_0000);
      // Remote defect accepted, then defect seconds
      frames(5, 3'b010, 0, 1, 0);
      check(32'(reports), 32'h0000_0008);
      check(32'(tsf), 32'h0000_0000);
      eq_fault <= 1'b1;
      pulse();
      check(32'(far_ds), 32'h0000_0001);
      check(32'(near_ds), 32'h0000_0001);
      check(32'(tsd), 32'h0000_0000);
      // Two bad seconds in a row declare degrade
      repeat (2) begin
         frames(1, 3'b010, 0, 1, 1);
         pulse();
      end
      @(posedge sys_clk);
      check(32'(tsd), 32'h0000_0001);
      check(32'(reports), 32'h0000_000C);
      // Unequipped label suppresses the remote defect report
      frames(5, 3'b000, 0, 1, 0);
      check(32'(tsf), 32'h0000_0001);
      check(32'(reports), 32'h0000_0005);
      end_of_test();
   end
endmodule // vc11_path_nonintrusive_monitor_tb

//--- verification/vc11_path_source.sv
// ======
// Remote path source: 104-byte frames, one idle cycle after each
module vc11_path_source (
   input  wire logic       sys_clk,
   output logic      [7:0] ci_byte,
   output logic            ci_byte_valid,
   output logic            ci_frame_start
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] parity_reg = 8'h00; // Column parity of the frame in flight
   initial begin
      ci_byte = 8'h00;
      ci_byte_valid = 1'b0;
      ci_frame_start = 1'b0;
   end
   // Path overhead byte first, trace at index 26, counting payload elsewhere
   task automatic send_frame(input logic [2:0] label, input logic rei,
                             input logic rdi, input logic bad_bip);
      logic [7:0] b;
      logic [7:0] p;
      p = parity_reg;
      parity_reg = 8'h00;
      for (int i = 0; i < 104; i++) begin
         if (i == 0) begin
            // Parity over the whole previous frame, optionally spoiled
            b = {^{p[7], p[5], p[3], p[1], bad_bip}, ^{p[6], p[4], p[2], p[0]},
                 rei, 1'b0, label, rdi};
         end else if (i == 26) begin
            b = 8'hA5;
         end else begin
            b = 8'(i * 37);
         end
         parity_reg = parity_reg ^ b;
         @(posedge sys_clk);
         ci_byte <= b;
         ci_byte_valid <= 1'b1;
         ci_frame_start <= (i == 0);
      end
      // Released line shows the inverse of the last byte
      @(posedge sys_clk);
      ci_byte <= ~b;
      ci_byte_valid <= 1'b0;
      ci_frame_start <= 1'b0;
   endtask
endmodule // vc11_path_source
